// file: verilog/cts_channel_two.sv
/*
 * Channel two display select, ratio, offset, expand, analog output and indicators,
 * with an APB register slave.
 * Assumes key, knob and trigger inputs are one-cycle pulses synchronous to pclk and
 * samples already normalised: Y and Y noise to sensitivity, aux inputs in mV,
 * phase in hundredths of a degree.
 */
`timescale 1ns/1ns
module cts_channel_two
    import cts_pkg::*;
#(
    parameter int unsigned SLOW_DIV_CYCLES = SLOW_DIV,
    parameter int unsigned TRIG_FLASH_LEN = TRIG_FLASH_CYCLES
) (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Front panel keys and knob.
    input wire logic display_key,
    input wire logic ratio_key,
    input wire logic output_key,
    input wire logic offset_key,
    input wire logic modify_key,
    input wire logic ref_key,
    input wire logic expand_key,
    input wire logic auto_offset_key,
    input wire logic knob_up,
    input wire logic knob_down,
    // Events and status from elsewhere in the instrument.
    input wire logic trig_in,
    input wire logic storage_triggered,
    input wire logic auto_busy,
    // Measured quantities.
    input wire logic signed [15:0] y_in,
    input wire logic signed [15:0] phase_in,
    input wire logic signed [15:0] ynoise_in,
    input wire logic signed [15:0] aux3_in,
    input wire logic signed [15:0] aux4_in,
    // Display and output.
    output logic signed [15:0] disp_value,
    output logic signed [7:0] bar_graph,
    output logic signed [15:0] channel_two_analog_output,
    output logic signed [15:0] ref_value,
    // Indicators.
    output logic output_overload_indicator,
    output logic auto_ind,
    output logic trig_ind,
    output logic ratio_ind,
    output logic aux3_den_ind,
    output logic aux4_den_ind,
    output logic offset_ind,
    output logic expand_ind,
    output logic modify_active
);
    function automatic logic signed [15:0] sat16(input logic signed [31:0] v);
        if (v > 32'sd32767) return 16'sh7FFF;
        if (v < -32'sd32767) return -16'sh7FFF;
        return v[15:0];
    endfunction

    function automatic logic signed [15:0] clamp_off(input logic signed [31:0] v);
        if (v > 32'(OFFSET_MAX)) return 16'(OFFSET_MAX);
        if (v < 32'(OFFSET_MIN)) return 16'(OFFSET_MIN);
        return v[15:0];
    endfunction

    function automatic logic signed [31:0] exp_mul(input logic signed [31:0] v, cts_exp_t e);
        case (e)
            cts_exp_x10: return v * 32'sd10;
            cts_exp_x100: return v * 32'sd100;
            default: return v;
        endcase
    endfunction

    function automatic logic signed [31:0] abs32(input logic signed [31:0] v);
        return (v < 0) ? -v : v;
    endfunction

    cts_disp_t disp_q;
    cts_ratio_t ratio_q;
    cts_exp_t exp_q;
    logic src_disp_q;
    logic offset_on_q;
    logic modify_q;
    logic auto_pend_q;
    logic signed [15:0] offset_q;
    logic [23:0] trig_cnt_q;
    logic [31:0] prdata_q;
    logic slverr_q;
    logic fast_tick;
    logic slow_tick;
    logic upd_tick;
    logic y_dep;
    logic cfg_wr;
    logic off_wr;
    logic map_hit;
    logic signed [31:0] y_off;
    logic signed [31:0] num;
    logic signed [31:0] den;
    logic signed [31:0] disp_full;
    logic signed [31:0] out_full;
    logic signed [15:0] out_next;
    logic signed [31:0] bar_full;

    cts_rate_tick #(.DIV(FAST_DIV)) u_fast (
        .pclk(pclk),
        .presetn(presetn),
        .tick(fast_tick)
    );

    cts_rate_tick #(.DIV(SLOW_DIV_CYCLES)) u_slow (
        .pclk(pclk),
        .presetn(presetn),
        .tick(slow_tick)
    );

    assign cfg_wr = psel && penable && pwrite && (paddr == REG_CONFIG);
    assign off_wr = psel && penable && pwrite && (paddr == REG_OFFSET);
    assign map_hit = (paddr == REG_CONFIG) || (paddr == REG_OFFSET) || (paddr == REG_STATUS)
                     || (paddr == REG_DISPLAY) || (paddr == REG_OUTPUT);

    // Selection state: APB writes win over keys pressed in the same cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            disp_q <= RST_DISP;
            ratio_q <= RST_RATIO;
            exp_q <= RST_EXP;
            src_disp_q <= 1'b0;
            offset_on_q <= 1'b0;
        end else if (cfg_wr) begin
            if ($onehot(pwdata[CFG_DISP_LSB +: 5])) disp_q <= cts_disp_t'(pwdata[CFG_DISP_LSB +: 5]);
            if ($onehot(pwdata[CFG_RAT_LSB +: 3])) ratio_q <= cts_ratio_t'(pwdata[CFG_RAT_LSB +: 3]);
            if ($onehot(pwdata[CFG_EXP_LSB +: 3])) exp_q <= cts_exp_t'(pwdata[CFG_EXP_LSB +: 3]);
            src_disp_q <= pwdata[CFG_SRC_BIT];
            offset_on_q <= pwdata[CFG_OFFON_BIT];
        end else begin
            if (display_key) begin
                case (disp_q)
                    cts_disp_y: disp_q <= cts_disp_phase;
                    cts_disp_phase: disp_q <= cts_disp_noise;
                    cts_disp_noise: disp_q <= cts_disp_aux3;
                    cts_disp_aux3: disp_q <= cts_disp_aux4;
                    default: disp_q <= cts_disp_y;
                endcase
            end
            if (ratio_key) begin
                case (ratio_q)
                    cts_rat_off: ratio_q <= cts_rat_aux3;
                    cts_rat_aux3: ratio_q <= cts_rat_aux4;
                    default: ratio_q <= cts_rat_off;
                endcase
            end
            if (expand_key) begin
                case (exp_q)
                    cts_exp_x1: exp_q <= cts_exp_x10;
                    cts_exp_x10: exp_q <= cts_exp_x100;
                    default: exp_q <= cts_exp_x1;
                endcase
            end
            if (output_key) src_disp_q <= !src_disp_q;
            if (auto_offset_key) offset_on_q <= 1'b1;
            else if (offset_key) offset_on_q <= !offset_on_q;
        end
    end

    // The stored offset is changed only by software, auto offset and the knob in modify mode.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            offset_q <= RST_OFFSET;
        end else if (off_wr) begin
            offset_q <= clamp_off(32'(signed'(pwdata[15:0])));
        end else if (auto_offset_key) begin
            offset_q <= clamp_off(32'(y_in));
        end else if (modify_q && (knob_up != knob_down)) begin
            offset_q <= clamp_off(32'(offset_q) + (knob_up ? 32'sd1 : -32'sd1));
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            modify_q <= 1'b0;
        end else if (ref_key) begin
            modify_q <= 1'b0;
        end else if (modify_key) begin
            modify_q <= 1'b1;
        end
    end

    // Datapath: offset acts on Y-based display, expand only on the analog output.
    assign y_off = 32'(y_in) - (offset_on_q ? 32'(offset_q) : 32'sd0);
    assign y_dep = (disp_q == cts_disp_y);
    assign den = (ratio_q == cts_rat_aux4) ? 32'(aux4_in) : 32'(aux3_in);

    always_comb begin
        case (disp_q)
            cts_disp_y: num = y_off;
            cts_disp_phase: num = 32'(phase_in);
            cts_disp_noise: num = 32'(ynoise_in);
            cts_disp_aux3: num = 32'(aux3_in);
            cts_disp_aux4: num = 32'(aux4_in);
            default: num = 32'sd0;
        endcase
        if (ratio_q == cts_rat_off) begin
            disp_full = num;
        end else if (den == 32'sd0) begin
            disp_full = (num < 0) ? -32'sd32767 : 32'sd32767;
        end else begin
            disp_full = (num * 32'(RATIO_SCALE)) / den;
        end
        if (src_disp_q) begin
            out_full = y_dep ? exp_mul(32'(sat16(disp_full)), exp_q) : disp_full;
        end else begin
            out_full = exp_mul(y_off, exp_q);
        end
        if (ratio_q == cts_rat_off && disp_q == cts_disp_phase) begin
            bar_full = 32'(sat16(disp_full)) * 32'(BAR_FULL) / 32'(PHASE_FS);
        end else begin
            bar_full = 32'(sat16(disp_full)) * 32'(BAR_FULL) / 32'(FS_COUNTS);
        end
    end

    assign out_next = sat16(out_full);
    assign upd_tick = src_disp_q ? slow_tick : fast_tick;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            disp_value <= 16'sh0000;
            bar_graph <= 8'sh00;
        end else begin
            disp_value <= sat16(disp_full);
            if (bar_full > 32'(BAR_FULL)) bar_graph <= 8'(BAR_FULL);
            else if (bar_full < -32'(BAR_FULL)) bar_graph <= -8'(BAR_FULL);
            else bar_graph <= bar_full[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            channel_two_analog_output <= 16'sh0000;
        end else if (upd_tick) begin
            channel_two_analog_output <= out_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            output_overload_indicator <= 1'b0;
        end else begin
            output_overload_indicator <= abs32(out_full) > 32'(OUTPUT_OVERLOAD_INDICATOR_LIMIT);
        end
    end

    // A trigger arriving while the flash runs restarts it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_cnt_q <= 24'h000000;
        end else if (trig_in && storage_triggered) begin
            trig_cnt_q <= 24'(TRIG_FLASH_LEN);
        end else if (trig_cnt_q != 24'h000000) begin
            trig_cnt_q <= trig_cnt_q - 24'h000001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) auto_pend_q <= 1'b0;
        else auto_pend_q <= auto_offset_key;
    end

    assign auto_ind = auto_busy || auto_pend_q;
    assign trig_ind = (trig_cnt_q != 24'h000000);
    assign ratio_ind = (ratio_q != cts_rat_off);
    assign aux3_den_ind = (ratio_q == cts_rat_aux3);
    assign aux4_den_ind = (ratio_q == cts_rat_aux4);
    assign offset_ind = offset_on_q && y_dep;
    assign expand_ind = (exp_q != cts_exp_x1);
    assign modify_active = modify_q;
    assign ref_value = offset_q;

    // APB: read data is captured in the setup cycle, so every access ends at once.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h00000000;
            slverr_q <= 1'b0;
        end else if (psel && !penable) begin
            slverr_q <= !map_hit;
            case (paddr)
                REG_CONFIG: prdata_q <= {19'h00000, ratio_q, exp_q, offset_on_q, src_disp_q, disp_q};
                REG_OFFSET: prdata_q <= {16'h0000, offset_q};
                REG_STATUS: prdata_q <= {23'h000000, modify_q, expand_ind, offset_ind, aux4_den_ind,
                                         aux3_den_ind, ratio_ind, trig_ind, auto_ind,
                                         output_overload_indicator};
                REG_DISPLAY: prdata_q <= {8'h00, bar_graph, disp_value};
                REG_OUTPUT: prdata_q <= {16'h0000, channel_two_analog_output};
                default: prdata_q <= 32'h00000000;
            endcase
        end
    end

    assign prdata = prdata_q;
    assign pready = 1'b1;
    assign pslverr = psel && penable && slverr_q;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_ratio_off_press;
        ratio_key && !cfg_wr && ratio_q == cts_rat_off;
    endsequence
    sequence s_ratio_last_press;
        ratio_key && !cfg_wr && ratio_q == cts_rat_aux4;
    endsequence

    chk_output_overload_indicator_set: assert property (abs32(out_full) > 32'(OUTPUT_OVERLOAD_INDICATOR_LIMIT) |=> output_overload_indicator)
        else $error("overload not raised above threshold");
    chk_output_overload_indicator_clear: assert property (abs32(out_full) <= 32'(OUTPUT_OVERLOAD_INDICATOR_LIMIT) |=> !output_overload_indicator)
        else $error("overload held within threshold");
    chk_auto_lamp: assert property (auto_busy |-> auto_ind)
        else $error("auto lamp dark during auto function");
    chk_trig_cause: assert property ($rose(trig_ind) |-> $past(trig_in && storage_triggered))
        else $error("trigger lamp rose without qualified trigger");
    chk_ratio_enter: assert property (s_ratio_off_press |=> aux3_den_ind && ratio_ind)
        else $error("ratio key did not select aux 3");
    chk_ratio_exit: assert property (s_ratio_last_press |=> !ratio_ind && !aux3_den_ind && !aux4_den_ind)
        else $error("ratio sequence did not end with lamps off");
    chk_offset_range: assert property (offset_q <= 16'(OFFSET_MAX) && offset_q >= 16'(OFFSET_MIN))
        else $error("offset outside allowed range");
    chk_offset_keep: assert property (offset_key && !off_wr && !auto_offset_key && !modify_q |=> $stable(offset_q))
        else $error("offset value changed by on/off key");
    chk_auto_offset: assert property (auto_offset_key && !off_wr |=> offset_q == clamp_off(32'($past(y_in))))
        else $error("auto offset did not track Y");
    chk_fast_update: assert property (!src_disp_q && fast_tick |=> channel_two_analog_output == $past(out_next))
        else $error("Y output missed its update");
    chk_slow_hold: assert property (src_disp_q && !slow_tick |=> $stable(channel_two_analog_output))
        else $error("display output changed between updates");
    chk_expand_disp: assert property (y_dep && ratio_q == cts_rat_off |=> disp_value == sat16($past(y_off)))
        else $error("displayed Y depends on expand");
    chk_modify_exit: assert property (modify_q && ref_key |=> !modify_q ##1 (!modify_q || $past(modify_key)))
        else $error("reference key did not leave modify mode");
    chk_expand_lamp: assert property (expand_ind == (exp_q == cts_exp_x10 || exp_q == cts_exp_x100))
        else $error("expand lamp wrong");
endmodule // cts_channel_two

// file: verilog/cts_pkg.sv
/*
 * Constants and types for the channel two display and output scaling block.
 * Assumes a 25 MHz pclk and signed 16-bit samples in which 10000 counts are full scale.
 */
package cts_pkg;
    // Value scaling: 10000 counts are full scale, 10 V or 100 %; phase full scale is 18000 counts, 180 degrees.
    localparam int FS_COUNTS = 10000;
    localparam int PHASE_FS = 18000;
    localparam int OUTPUT_OVERLOAD_INDICATOR_LIMIT = 10900;
    localparam int OFFSET_MAX = 10500;
    localparam int OFFSET_MIN = -10500;
    localparam int RATIO_SCALE = 10000;
    localparam int BAR_FULL = 100;

    // Update rates and the cycle counts derived from them.
    localparam int unsigned CLK_HZ = 25000000;
    localparam int unsigned FAST_RATE_HZ = 256000;
    localparam int unsigned SLOW_RATE_HZ = 512;
    localparam int unsigned FAST_DIV = CLK_HZ / FAST_RATE_HZ;
    localparam int unsigned SLOW_DIV = CLK_HZ / SLOW_RATE_HZ;
    localparam int unsigned TRIG_FLASH_MS = 50;
    localparam int unsigned TRIG_FLASH_CYCLES = CLK_HZ / 1000 * TRIG_FLASH_MS;

    // Register byte offsets.
    localparam logic [7:0] REG_CONFIG = 8'h00;
    localparam logic [7:0] REG_OFFSET = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_DISPLAY = 8'h0C;
    localparam logic [7:0] REG_OUTPUT = 8'h10;

    // Configuration field positions.
    localparam int CFG_DISP_LSB = 0;
    localparam int CFG_SRC_BIT = 5;
    localparam int CFG_OFFON_BIT = 6;
    localparam int CFG_EXP_LSB = 7;
    localparam int CFG_RAT_LSB = 10;

    // Status bit positions.
    localparam int ST_OUTPUT_OVERLOAD_INDICATOR_BIT = 0;
    localparam int ST_AUTO_BIT = 1;
    localparam int ST_TRIG_BIT = 2;
    localparam int ST_RATIO_BIT = 3;
    localparam int ST_DEN3_BIT = 4;
    localparam int ST_DEN4_BIT = 5;
    localparam int ST_OFFSET_BIT = 6;
    localparam int ST_EXPAND_BIT = 7;
    localparam int ST_MODIFY_BIT = 8;

    typedef enum logic [4:0] {
        cts_disp_y = 5'h01,
        cts_disp_phase = 5'h02,
        cts_disp_noise = 5'h04,
        cts_disp_aux3 = 5'h08,
        cts_disp_aux4 = 5'h10
    } cts_disp_t;

    typedef enum logic [2:0] {
        cts_rat_off = 3'h1,
        cts_rat_aux3 = 3'h2,
        cts_rat_aux4 = 3'h4
    } cts_ratio_t;

    typedef enum logic [2:0] {
        cts_exp_x1 = 3'h1,
        cts_exp_x10 = 3'h2,
        cts_exp_x100 = 3'h4
    } cts_exp_t;

    // Values after reset.
    localparam cts_disp_t RST_DISP = cts_disp_y;
    localparam cts_ratio_t RST_RATIO = cts_rat_off;
    localparam cts_exp_t RST_EXP = cts_exp_x1;
    localparam logic signed [15:0] RST_OFFSET = 16'sh0000;
endpackage

// file: verilog/cts_rate_tick.sv
/*
 * Free-running divider that pulses once every DIV clock cycles.
 * Assumes DIV is at least 2 and below 2**24.
 */
`timescale 1ns/1ns
module cts_rate_tick #(
    parameter int unsigned DIV = 2
) (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Update strobe.
    output logic tick
);
    logic [23:0] cnt_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 24'h000000;
            tick <= 1'b0;
        end else begin
            tick <= (cnt_q == 24'(DIV - 1));
            cnt_q <= (cnt_q == 24'(DIV - 1)) ? 24'h000000 : cnt_q + 24'h000001;
        end
    end
endmodule // cts_rate_tick

// file: tb/cts_panel_model.sv
/*
 * Front-panel operator model: presses one key or knob step at a time.
 * Assumes the bench raises key_go for one cycle per press and that the block samples
 * keys on rising pclk edges.
 */
`timescale 1ns/1ns
module cts_panel_model (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Press request: key index and a one-cycle go strobe.
    input wire logic [3:0] key_sel,
    input wire logic key_go,
    // Pulses: display, ratio, output, offset, modify, ref, expand, auto, knob up, knob down.
    output logic [9:0] key_pulse
);
    // Each request becomes one high cycle on the chosen key, one cycle after the request.
    // A slow operator simply waits longer between requests.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            key_pulse <= 10'h000;
        end else begin
            key_pulse <= key_go ? (10'h001 << key_sel) : 10'h000;
        end
    end
endmodule // cts_panel_model

// file: tb/test_channel_two_output_scaling.sv
/*
 * Self-checking bench for the channel two display and output block.
 * Assumes a 25 MHz pclk, zero-wait APB and shortened slow and flash counts.
 */
`timescale 1ns/1ns
module test_channel_two_output_scaling;
    import cts_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd_q;
    logic pready, pslverr, err_q;
    logic [9:0] key_pulse;
    logic [3:0] key_sel = 4'h0;
    logic key_go = 1'b0;
    logic trig_in = 1'b0, storage_triggered = 1'b0, auto_busy = 1'b0;
    logic signed [15:0] y_in = 3000, phase_in = 9000, ynoise_in = 1500;
    logic signed [15:0] aux3_in = 5000, aux4_in = 2000;
    logic signed [15:0] disp_value, channel_two_analog_output, ref_value;
    logic signed [7:0] bar_graph;
    logic output_overload_indicator, auto_ind, trig_ind, ratio_ind, aux3_den_ind;
    logic aux4_den_ind, offset_ind, expand_ind, modify_active;
    int err_count = 0, cmp_count = 0, cycles = 0;
    logic [4:0] disp_code[5] = '{5'h02, 5'h04, 5'h08, 5'h10, 5'h01};
    int disp_exp[5] = '{9000, 1500, 5000, 2000, 3000};
    int bar_exp[5] = '{50, 15, 50, 20, 30};
    logic [2:0] rat_exp[3] = '{3'h6, 3'h5, 3'h0};
    int rat_disp[3] = '{6000, 15000, 3000};
    int exp_out[3] = '{30000, 32767, 3000};
    logic [1:0] exp_lamps[3] = '{2'h3, 2'h3, 2'h0};

    cts_channel_two #(.SLOW_DIV_CYCLES(20), .TRIG_FLASH_LEN(5)) cts_channel_two_inst (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .display_key(key_pulse[0]), .ratio_key(key_pulse[1]), .output_key(key_pulse[2]),
        .offset_key(key_pulse[3]), .modify_key(key_pulse[4]), .ref_key(key_pulse[5]),
        .expand_key(key_pulse[6]), .auto_offset_key(key_pulse[7]),
        .knob_up(key_pulse[8]), .knob_down(key_pulse[9]),
        .trig_in, .storage_triggered, .auto_busy, .y_in, .phase_in, .ynoise_in, .aux3_in,
        .aux4_in, .disp_value, .bar_graph, .channel_two_analog_output, .ref_value,
        .output_overload_indicator, .auto_ind, .trig_ind, .ratio_ind, .aux3_den_ind,
        .aux4_den_ind, .offset_ind, .expand_ind, .modify_active);

    cts_panel_model cts_panel_model_inst (.pclk, .presetn, .key_sel, .key_go, .key_pulse);

    always #20 pclk = ~pclk;

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s: expected %0h seen %0h", n, e, g);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask

    // One APB transfer; the request is held until pready is seen high at an edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk($sformatf("register %0h", a), e, rd_q);
    endtask

    // A press asks the panel model for one key pulse; the block sees it one cycle later.
    task automatic press(input int k);
        @(posedge pclk);
        key_sel <= 4'(k);
        key_go <= 1'b1;
        @(posedge pclk);
        key_go <= 1'b0;
    endtask

    task automatic trig_pulse(input logic qual);
        @(posedge pclk) storage_triggered <= qual;
        @(posedge pclk) trig_in <= 1'b1;
        @(posedge pclk) trig_in <= 1'b0;
        step(1);
        chk("trig_ind", qual, trig_ind);
    endtask

    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(REG_CONFIG, 32'h0000_0481);
        for (int i = 0; i < 5; i++) begin
            press(0);
            step(2);
            rdchk(REG_CONFIG, 32'h0000_0480 | disp_code[i]);
            chk("disp_value", disp_exp[i], disp_value);
            chk("bar_graph", bar_exp[i], bar_graph);
        end
        for (int i = 0; i < 3; i++) begin
            press(1);
            step(2);
            chk("ratio lamps", rat_exp[i], {ratio_ind, aux3_den_ind, aux4_den_ind});
            chk("ratio value", rat_disp[i], disp_value);
        end
        for (int i = 0; i < 3; i++) begin
            press(6);
            step(120);
            chk("expand lamp", exp_lamps[i][0], expand_ind);
            chk("output", exp_out[i], channel_two_analog_output);
            chk("overload", exp_lamps[i][1], output_overload_indicator);
            chk("expanded display", 3000, disp_value);
        end
        @(posedge pclk) y_in <= 10900;
        step(120);
        chk("overload edge", 1'b0, output_overload_indicator);
        @(posedge pclk) y_in <= 10901;
        step(120);
        chk("overload over", 1'b1, output_overload_indicator);
        @(posedge pclk) y_in <= 3000;
        apb(1'b1, REG_OFFSET, 32'h0000_4E20);
        rdchk(REG_OFFSET, 32'h0000_2904);
        apb(1'b1, REG_OFFSET, 32'h0000_B1E0);
        rdchk(REG_OFFSET, 32'h0000_D6FC);
        apb(1'b1, REG_OFFSET, 32'h0000_03E8);
        press(3);
        step(120);
        chk("offset lamp", 1'b1, offset_ind);
        chk("offset display", 2000, disp_value);
        chk("offset output", 2000, channel_two_analog_output);
        press(4);
        step(2);
        chk("modify", 1'b1, modify_active);
        press(8);
        press(9);
        press(9);
        step(2);
        chk("ref_value", 999, ref_value);
        chk("live display", 2001, disp_value);
        press(5);
        press(8);
        press(3);
        step(2);
        chk("modify exit", 2'h0, {modify_active, offset_ind});
        rdchk(REG_OFFSET, 32'h0000_03E7);
        @(posedge pclk) y_in <= 2500;
        press(7);
        step(120);
        chk("auto offset", 2500, ref_value);
        chk("zeroed output", 0, channel_two_analog_output);
        press(0);
        step(2);
        chk("phase display", 9000, disp_value);
        chk("phase lamp", 1'b0, offset_ind);
        repeat (4) press(0);
        @(posedge pclk) auto_busy <= 1'b1;
        step(1);
        chk("auto_ind", 1'b1, auto_ind);
        @(posedge pclk) auto_busy <= 1'b0;
        step(2);
        chk("auto_ind", 1'b0, auto_ind);
        trig_pulse(1'b0);
        trig_pulse(1'b1);
        step(7);
        chk("trig end", 1'b0, trig_ind);
        press(2);
        @(posedge pclk) y_in <= 4000;
        step(25);
        chk("display output", 1500, channel_two_analog_output);
        rdchk(REG_STATUS, 32'h0000_0040);
        rdchk(REG_DISPLAY, 32'h000F_05DC);
        rdchk(REG_OUTPUT, 32'h0000_05DC);
        rdchk(REG_CONFIG, 32'h0000_04E1);
        @(posedge pclk) phase_in <= -16'sd4500;
        ynoise_in <= 16'sd800;
        aux3_in <= -16'sd2000;
        aux4_in <= 16'sd4000;
        apb(1'b1, REG_CONFIG, 32'h0000_1104);
        step(120);
        rdchk(REG_CONFIG, 32'h0000_1104);
        chk("noise ratio", 2000, disp_value);
        chk("ratio bar", 20, bar_graph);
        chk("aux 4 lamps", 3'h5, {ratio_ind, aux3_den_ind, aux4_den_ind});
        chk("saturated output", 32767, channel_two_analog_output);
        chk("expand overload", 1'b1, output_overload_indicator);
        chk("lamps off Y", 2'h2, {expand_ind, offset_ind});
        apb(1'b1, REG_CONFIG, 32'h0000_0403);
        rdchk(REG_CONFIG, 32'h0000_0504);
        chk("noise display", 800, disp_value);
        apb(1'b1, REG_CONFIG, 32'h0000_0408);
        step(2);
        chk("aux 3 display", -2000, disp_value);
        chk("aux 3 bar", -20, bar_graph);
        apb(1'b1, REG_CONFIG, 32'h0000_0502);
        step(2);
        chk("negative phase", -4500, disp_value);
        chk("phase bar", -25, bar_graph);
        apb(1'b0, 8'h20, 32'h0000_0000);
        chk("unmapped error", 1'b1, err_q);
        chk("unmapped data", 32'h0000_0000, rd_q);
        end_of_test();
    end
endmodule // test_channel_two_output_scaling
